// ### core/store_pkg.sv
// shared widths, encodings and constants for the register store unit
// assumes the core supplies the effective address already formed
package store_pkg;

    // ==========================================================
    // widths
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int REGN_W = 5;
    localparam int SRC_WORDS = 4;
    localparam int BYTE_W = 8;
    localparam int HALF_W = 16;

    // ==========================================================
    // store variants
    typedef enum logic [2:0] {
        write_word      = 3'h0,
        write_ord_byte  = 3'h1,
        write_ord_half  = 3'h2,
        write_int_byte  = 3'h3,
        write_int_half  = 3'h4,
        write_long      = 3'h5,
        write_triple    = 3'h6,
        write_quad      = 3'h7
    } store_op_e;

    // fault codes reported at the end of an instruction
    typedef enum logic [2:0] {
        flt_none                = 3'h0,
        fault_a                 = 3'h1,
        bad_operand_fault       = 3'h2,
        misaligned_access_fault = 3'h3,
        arith_overflow_fault    = 3'h4
    } fault_code_e;

    // width of one memory write beat
    typedef enum logic [1:0] {
        size_byte = 2'h0,
        size_half = 2'h1,
        size_word = 2'h2
    } write_size_e;

    // ==========================================================
    // address and data constants
    localparam logic [ADDR_W-1:0] WORD_STEP = 32'h00000004;
    localparam logic [3:0] MASK_HALF = 4'h1;
    localparam logic [3:0] MASK_WORD = 4'h3;
    localparam logic [3:0] MASK_LONG = 4'h7;
    localparam logic [3:0] MASK_QUAD = 4'hF;
    localparam logic [3:0] MASK_NONE = 4'h0;
    localparam logic [DATA_W-1:0] BYTE_MASK = 32'h000000FF;
    localparam logic [DATA_W-1:0] HALF_MASK = 32'h0000FFFF;
    localparam logic [1:0] LAST_ONE = 2'h0;
    localparam logic [1:0] LAST_TWO = 2'h1;
    localparam logic [1:0] LAST_THREE = 2'h2;
    localparam logic [1:0] LAST_FOUR = 2'h3;
    localparam logic [1:0] IDX_ONE = 2'h1;
    localparam logic [2:0] CNT_ONE = 3'h1;

endpackage

// ### core/store_chk_if.sv
// bundle between the store sequencer, its checker and its formatter
// assumes all three sit on the same core clock
interface store_chk_if;
    import store_pkg::*;

    store_op_e op;
    logic [REGN_W-1:0] src_num;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] src0;
    logic unal_en;
    logic prot;
    logic type_f;
    logic operand_f;
    logic misalign;
    logic overflow;
    logic [1:0] last_idx;
    logic [DATA_W-1:0] word;
    logic [DATA_W-1:0] wdata;
    write_size_e size;

    modport core (output op, src_num, addr, src0, unal_en, prot, word,
                  input type_f, operand_f, misalign, overflow, last_idx,
                  wdata, size);
    modport chk (input op, src_num, addr, src0, unal_en, prot,
                 output type_f, operand_f, misalign, overflow, last_idx);
    modport fmt (input op, word, output wdata, size);
endinterface

// ### core/store_check.sv
// fault classification for one store request, purely combinational
// assumes the protection verdict arrives from the memory map logic
module store_check (
    store_chk_if.chk c // request in, verdicts out
);
    import store_pkg::*;

    // ==========================================================
    // register number and alignment
    wire is_long = (c.op == write_long);
    wire is_tq = (c.op == write_triple) || (c.op == write_quad);
    wire is_half = (c.op == write_ord_half) || (c.op == write_int_half);
    wire [3:0] amask = is_tq ? MASK_QUAD :
                       is_long ? MASK_LONG :
                       (c.op == write_word) ? MASK_WORD :
                       is_half ? MASK_HALF : MASK_NONE;

    // protection verdict is passed through untouched
    assign c.type_f = c.prot;
    assign c.operand_f = (is_long && c.src_num[0]) ||
                         (is_tq && (c.src_num[1:0] != 2'h0));
    assign c.misalign = c.unal_en && ((c.addr[3:0] & amask) != 4'h0);

    // ==========================================================
    // signed narrow range: upper bits must all match
    wire [DATA_W-BYTE_W-1:0] hi_b = c.src0[DATA_W-1:BYTE_W];
    wire [DATA_W-HALF_W-1:0] hi_h = c.src0[DATA_W-1:HALF_W];
    wire ovf_b = (|hi_b) && !(&hi_b);
    wire ovf_h = (|hi_h) && !(&hi_h);
    // misalignment outranks overflow on the signed half store
    assign c.overflow = ((c.op == write_int_byte) && ovf_b) ||
                        ((c.op == write_int_half) && ovf_h &&
                         !c.misalign);

    // beats per instruction, minus one
    assign c.last_idx = (c.op == write_quad) ? LAST_FOUR :
                        (c.op == write_triple) ? LAST_THREE :
                        is_long ? LAST_TWO : LAST_ONE;
endmodule

// ### core/store_format.sv
// shapes one source word into a memory write beat
// assumes byte-lane steering by endianness happens downstream
module store_format (
    store_chk_if.fmt f // word in, beat out
);
    import store_pkg::*;

    // ==========================================================
    // narrow variants keep only their low bits
    wire nb = (f.op == write_ord_byte) || (f.op == write_int_byte);
    wire nh = (f.op == write_ord_half) || (f.op == write_int_half);

    assign f.wdata = nb ? (f.word & BYTE_MASK) :
                     nh ? (f.word & HALF_MASK) : f.word;
    assign f.size = nb ? size_byte : nh ? size_half : size_word;
endmodule

// ### core/store_unit.sv
// sequencer for the register-to-memory store family
// assumes the address is formed upstream and the write path
// takes one word beat per mem_wr_valid and mem_wr_ready handshake
// Summary of operation
// - destination address from any addressing mode is taken as given.
// - byte stores write low 8 bits, half stores low 16 bits.
// - unsigned narrow stores truncate silently, never overflow.
// - signed overflow still writes; sets flag if masked, else faults.
// - signed byte overflows when bits 31..8 are mixed.
// - signed half overflows when bits 31..16 are mixed.
// - word, long, triple, quad write 4, 8, 12, 16 bytes from registers.
// - long store from odd register: operand fault, no write.
// - triple or quad from register not multiple of four: operand fault.
// - protection check first; violation gives type fault, no write.
// - misaligned half store with checking on: write, then fault.
// - misaligned word/long/triple/quad with checking on: write all, fault.
// - word k of a group goes to address plus four times k.
// - register check after protection, before alignment check.
module store_unit (
    input wire logic core_clk, // core clock, 50 MHz
    input wire logic rst_b, // synchronous reset, active low
    input wire logic req_valid, // store request present
    output logic req_ready, // unit idle, can take a request
    input wire store_pkg::store_op_e req_op, // store variant
    input wire logic [store_pkg::REGN_W-1:0] req_src_num, // first reg
    input wire logic [store_pkg::ADDR_W-1:0] req_addr, // effective addr
    input wire logic [4*store_pkg::DATA_W-1:0] req_src, // regs n..n+3
    input wire logic req_prot, // write hits protected ram or regs
    input wire logic unal_fault_en, // unaligned fault checking on
    input wire logic overflow_mask_bit, // overflow masked into flag
    output logic mem_wr_valid, // write beat present
    input wire logic mem_wr_ready, // write path takes the beat
    output logic [store_pkg::ADDR_W-1:0] mem_wr_addr, // beat address
    output logic [store_pkg::DATA_W-1:0] mem_wr_data, // beat data
    output store_pkg::write_size_e mem_wr_size, // beat width
    output logic done, // instruction finished, one cycle
    output logic fault_valid, // fault with done, one cycle
    output store_pkg::fault_code_e fault_code, // which fault
    output logic overflow_flag_bit // set overflow flag, one cycle
);
    import store_pkg::*;

    // ==========================================================
    // state
    typedef enum logic [1:0] {
        st_idle  = 2'h0,
        st_write = 2'h1,
        st_done  = 2'h2
    } seq_state_e;

    seq_state_e state_reg, state_next;
    logic ready_reg;
    logic wvalid_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [DATA_W-1:0] wdata_reg;
    write_size_e wsize_reg;
    logic done_reg;
    logic fvalid_reg;
    fault_code_e fcode_reg;
    logic ovf_set_reg;
    store_op_e op_reg;
    logic [4*DATA_W-1:0] src_reg;
    logic [1:0] idx_reg;
    logic [1:0] last_reg;
    fault_code_e pend_reg, pend_next;
    logic pend_ovf_reg, pend_ovf_next;
    logic om_reg;
    logic [2:0] beat_cnt_reg;

    store_chk_if ci();

    // ==========================================================
    // helpers: fault checker and beat formatter
    store_check u_check (
        .c(ci.chk)
    );

    store_format u_format (
        .f(ci.fmt)
    );

    // ==========================================================
    // request decode
    wire accept = req_valid && ready_reg;
    wire beat_take = wvalid_reg && mem_wr_ready;
    wire last_beat = (idx_reg == last_reg);
    wire early_fault = ci.type_f || ci.operand_f;
    wire [1:0] idx_sel = accept ? 2'h0 : idx_reg + IDX_ONE;
    wire [4*DATA_W-1:0] src_sel = accept ? req_src : src_reg;

    // checker and formatter see the live op on accept; the captured op drives later beats
    assign ci.op = accept ? req_op : op_reg;
    assign ci.src_num = req_src_num;
    assign ci.addr = req_addr;
    assign ci.src0 = req_src[DATA_W-1:0];
    assign ci.unal_en = unal_fault_en;
    assign ci.prot = req_prot;
    // register n+k feeds beat k
    assign ci.word = src_sel[idx_sel*DATA_W +: DATA_W];

    // ==========================================================
    // fault selection in documented priority
    always_comb begin
        pend_next = flt_none;
        pend_ovf_next = 1'b0;
        if (ci.type_f) begin
            pend_next = fault_a;
        end else if (ci.operand_f) begin
            pend_next = bad_operand_fault;
        end else if (ci.misalign) begin
            pend_next = misaligned_access_fault;
        end else if (ci.overflow) begin
            pend_ovf_next = overflow_mask_bit;
            pend_next = overflow_mask_bit ? flt_none : arith_overflow_fault;
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            st_idle: begin
                if (accept) begin
                    state_next = early_fault ? st_done : st_write;
                end
            end
            st_write: begin
                if (beat_take && last_beat) begin
                    state_next = st_done;
                end
            end
            st_done: begin
                state_next = st_idle;
            end
            default: begin
                state_next = st_idle;
            end
        endcase
    end

    // ==========================================================
    // sequencer state and captured request
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= st_idle;
            op_reg <= write_word;
            src_reg <= '0;
            last_reg <= 2'h0;
            pend_reg <= flt_none;
            pend_ovf_reg <= 1'b0;
            om_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (accept) begin
                op_reg <= req_op;
                src_reg <= req_src;
                last_reg <= ci.last_idx;
                pend_reg <= pend_next;
                pend_ovf_reg <= pend_ovf_next;
                om_reg <= overflow_mask_bit;
            end
        end
    end

    // ready is low for the whole instruction
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= (state_next == st_idle);
        end
    end

    // ==========================================================
    // write beats; type and operand fault requests never raise valid
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wvalid_reg <= 1'b0;
            idx_reg <= 2'h0;
            waddr_reg <= '0;
            wdata_reg <= '0;
            wsize_reg <= size_word;
        end else if (accept) begin
            wvalid_reg <= !early_fault;
            idx_reg <= 2'h0;
            waddr_reg <= req_addr;
            wdata_reg <= ci.wdata;
            wsize_reg <= ci.size;
        end else if (beat_take) begin
            wvalid_reg <= !last_beat;
            idx_reg <= idx_sel;
            waddr_reg <= waddr_reg + WORD_STEP;
            wdata_reg <= ci.wdata;
            wsize_reg <= ci.size;
        end
    end

    // ==========================================================
    // completion report, one cycle after st_done, two after the last beat is taken
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            done_reg <= 1'b0;
            fvalid_reg <= 1'b0;
            fcode_reg <= flt_none;
            ovf_set_reg <= 1'b0;
        end else begin
            done_reg <= (state_reg == st_done);
            fvalid_reg <= (state_reg == st_done) && (pend_reg != flt_none);
            fcode_reg <= (state_reg == st_done) ? pend_reg : flt_none;
            ovf_set_reg <= (state_reg == st_done) && pend_ovf_reg;
        end
    end

    // beats taken by the write path, checked against fault reports
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            beat_cnt_reg <= 3'h0;
        end else if (accept) begin
            beat_cnt_reg <= 3'h0;
        end else if (beat_take) begin
            beat_cnt_reg <= beat_cnt_reg + CNT_ONE;
        end
    end

    assign req_ready = ready_reg;
    assign mem_wr_valid = wvalid_reg;
    assign mem_wr_addr = waddr_reg;
    assign mem_wr_data = wdata_reg;
    assign mem_wr_size = wsize_reg;
    assign done = done_reg;
    assign fault_valid = fvalid_reg;
    assign fault_code = fcode_reg;
    assign overflow_flag_bit = ovf_set_reg;

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence take_prot_s;
        accept && req_prot;
    endsequence

    sequence take_badreg_s;
        accept && !req_prot && ci.operand_f;
    endsequence

    sequence silent_report_s(fault_code_e code);
        !wvalid_reg ##1 (!wvalid_reg && done_reg && fvalid_reg &&
                         fcode_reg == code);
    endsequence

    type_no_write_a: assert property (
        take_prot_s |=> silent_report_s(fault_a))
        else $error("protected store wrote or missed type fault");

    operand_no_write_a: assert property (
        take_badreg_s |=> silent_report_s(bad_operand_fault))
        else $error("bad register store wrote or missed fault");

    long_odd_reg_a: assert property (
        accept && !req_prot && (req_op == write_long) && req_src_num[0]
        |=> ##1 (fcode_reg == bad_operand_fault))
        else $error("odd register long store not refused");

    byte_lane_a: assert property (
        wvalid_reg && (wsize_reg == size_byte)
        |-> (wdata_reg & ~BYTE_MASK) == '0)
        else $error("byte beat carries upper bits");

    half_lane_a: assert property (
        wvalid_reg && (wsize_reg == size_half)
        |-> (wdata_reg & ~HALF_MASK) == '0)
        else $error("half beat carries upper bits");

    addr_step_a: assert property (
        beat_take && !last_beat
        |=> wvalid_reg && (waddr_reg == $past(waddr_reg) + WORD_STEP))
        else $error("next beat address not four bytes on");

    ovf_only_signed_a: assert property (
        (fvalid_reg && fcode_reg == arith_overflow_fault) ||
        ovf_set_reg
        |-> (op_reg == write_int_byte) || (op_reg == write_int_half))
        else $error("overflow reported for unsigned store");

    ovf_mask_path_a: assert property (
        ovf_set_reg |-> om_reg && done_reg && !fvalid_reg)
        else $error("overflow flag set without mask bit");

    byte_ovf_detect_a: assert property (
        accept && !req_prot && (req_op == write_int_byte) &&
        !overflow_mask_bit && (|req_src[DATA_W-1:BYTE_W]) &&
        !(&req_src[DATA_W-1:BYTE_W])
        |=> wvalid_reg &&
            (wdata_reg == ($past(req_src[DATA_W-1:0]) & BYTE_MASK)))
        else $error("signed byte overflow skipped the write");

    misalign_all_a: assert property (
        done_reg && fcode_reg == misaligned_access_fault
        |-> beat_cnt_reg == {1'b0, last_reg} + CNT_ONE)
        else $error("misaligned store skipped beats");

    busy_not_ready_a: assert property (
        state_reg != st_idle |-> !ready_reg)
        else $error("ready raised while busy");
endmodule

// ### tb/mem_sink.sv
// model of the data memory write path facing the store unit
// assumes one beat per valid and ready handshake on the core clock
module mem_sink (
    input wire logic core_clk, // core clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic slow, // stall two cycles of every three
    input wire logic clr, // forget captured beats
    input wire logic mem_wr_valid, // beat present
    output logic mem_wr_ready, // beat taken
    input wire logic [31:0] mem_wr_addr, // beat address
    input wire logic [31:0] mem_wr_data, // beat data
    input wire store_pkg::write_size_e mem_wr_size, // beat width
    output logic [31:0] beat_addr [4], // captured addresses
    output logic [31:0] beat_data [4], // captured data
    output store_pkg::write_size_e beat_size, // last beat width
    output int beat_cnt // beats since clr
);
    timeunit 1ns;
    timeprecision 100ps;
    import store_pkg::*;

    // ==========================================================
    // ready pattern
    logic [1:0] phase_reg;

    // slow mode holds the unit waiting, so beats must stand meanwhile
    always_ff @(posedge core_clk) begin
        if (!rst_b || phase_reg == 2'h2) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end
    assign mem_wr_ready = !slow || phase_reg == 2'h2;

    // ==========================================================
    // beat capture
    // more than four beats would overrun the log, so excess is dropped
    always_ff @(posedge core_clk) begin
        if (!rst_b || clr) begin
            beat_cnt <= 0;
        end else if (mem_wr_valid && mem_wr_ready && beat_cnt < 4) begin
            beat_addr[beat_cnt] <= mem_wr_addr;
            beat_data[beat_cnt] <= mem_wr_data;
            beat_size <= mem_wr_size;
            beat_cnt <= beat_cnt + 1;
        end
    end
endmodule

// ### tb/test_register_store_unit.sv
// self-checking bench for the register store unit
// assumes the memory path model in mem_sink.sv
module test_register_store_unit;
    timeunit 1ns;
    timeprecision 100ps;
    import store_pkg::*;

    // ==========================================================
    // signals
    typedef struct {
        store_op_e op;
        logic [4:0] sn;
        logic [31:0] ad;
        logic [31:0] s0;
        logic ue, om, pr;
        int nb;
        fault_code_e fc;
        logic of;
    } row_s;

    logic core_clk, rst_b, req_valid, req_ready, req_prot;
    logic unal_fault_en, overflow_mask_bit, mem_wr_valid, mem_wr_ready;
    logic done, fault_valid, overflow_flag_bit, slow, clr;
    store_op_e req_op;
    logic [4:0] req_src_num;
    logic [31:0] req_addr, mem_wr_addr, mem_wr_data;
    logic [127:0] req_src;
    write_size_e mem_wr_size, beat_size;
    fault_code_e fault_code;
    logic [31:0] beat_addr [4];
    logic [31:0] beat_data [4];
    int beat_cnt, n_errors, checked;

    // ==========================================================
    // ordinary cases: request beside beats and verdict expected
    row_s rows [23] = '{
        '{write_word, 0, 32'h100, 32'h12345678, 1, 0, 0, 1, flt_none, 0},
        '{write_ord_byte, 0, 32'h103, 32'h12345678, 1, 0, 0, 1, flt_none, 0},
        '{write_ord_half, 0, 32'h102, 32'h8765ABCD, 1, 0, 0, 1, flt_none, 0},
        '{write_int_byte, 0, 32'h101, 32'hFFFFFF80, 1, 0, 0, 1, flt_none, 0},
        '{write_int_byte, 0, 32'h101, 32'h00000180, 1, 0, 0, 1,
          arith_overflow_fault, 0},
        '{write_int_byte, 0, 32'h101, 32'h00000180, 1, 1, 0, 1, flt_none, 1},
        '{write_int_half, 0, 32'h102, 32'h00018000, 1, 0, 0, 1,
          arith_overflow_fault, 0},
        '{write_int_half, 0, 32'h102, 32'hFFFF8000, 1, 0, 0, 1, flt_none, 0},
        '{write_long, 2, 32'h108, 32'h01010101, 1, 0, 0, 2, flt_none, 0},
        '{write_triple, 4, 32'h110, 32'h02020202, 1, 0, 0, 3, flt_none, 0},
        '{write_quad, 8, 32'h120, 32'h03030303, 1, 0, 0, 4, flt_none, 0},
        '{write_long, 3, 32'h108, 32'h0, 1, 0, 0, 0, bad_operand_fault, 0},
        '{write_triple, 6, 32'h110, 32'h0, 1, 0, 0, 0, bad_operand_fault, 0},
        '{write_quad, 2, 32'h120, 32'h0, 1, 0, 0, 0, bad_operand_fault, 0},
        '{write_quad, 2, 32'h121, 32'h0, 1, 0, 1, 0, fault_a, 0},
        '{write_word, 0, 32'h100, 32'h0, 1, 0, 1, 0, fault_a, 0},
        '{write_ord_half, 0, 32'h101, 32'h1234, 1, 0, 0, 1,
          misaligned_access_fault, 0},
        '{write_ord_half, 0, 32'h101, 32'h1234, 0, 0, 0, 1, flt_none, 0},
        '{write_word, 0, 32'h102, 32'h55, 1, 0, 0, 1,
          misaligned_access_fault, 0},
        '{write_long, 2, 32'h104, 32'h66, 1, 0, 0, 2,
          misaligned_access_fault, 0},
        '{write_quad, 4, 32'h108, 32'h77, 1, 0, 0, 4,
          misaligned_access_fault, 0},
        '{write_quad, 1, 32'h101, 32'h0, 1, 0, 0, 0, bad_operand_fault, 0},
        '{write_int_half, 0, 32'h101, 32'h00018000, 1, 0, 0, 1,
          misaligned_access_fault, 0}
    };

    store_unit store_unit_i (.core_clk(core_clk), .rst_b(rst_b),
        .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_src_num(req_src_num), .req_addr(req_addr),
        .req_src(req_src), .req_prot(req_prot),
        .unal_fault_en(unal_fault_en),
        .overflow_mask_bit(overflow_mask_bit),
        .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .mem_wr_size(mem_wr_size), .done(done),
        .fault_valid(fault_valid), .fault_code(fault_code),
        .overflow_flag_bit(overflow_flag_bit));

    mem_sink mem_sink_i (.core_clk(core_clk), .rst_b(rst_b), .slow(slow),
        .clr(clr), .mem_wr_valid(mem_wr_valid),
        .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data), .mem_wr_size(mem_wr_size),
        .beat_addr(beat_addr), .beat_data(beat_data),
        .beat_size(beat_size), .beat_cnt(beat_cnt));

    // ==========================================================
    // clock and helpers
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one request, held until taken, then the verdict at done
    task automatic run(input row_s r, input logic slw);
        int w;
        logic [31:0] m;
        write_size_e sz;
        @(posedge core_clk);
        slow <= slw;
        clr <= 1'b1;
        req_valid <= 1'b1;
        req_op <= r.op;
        req_src_num <= r.sn;
        req_addr <= r.ad;
        req_src <= {32'hD0D0D0D3, 32'hC0C0C0C2, 32'hB0B0B0B1, r.s0};
        req_prot <= r.pr;
        unal_fault_en <= r.ue;
        overflow_mask_bit <= r.om;
        w = 0;
        do begin
            @(posedge core_clk);
            w++;
        end while (req_ready !== 1'b1 && w < 50);
        req_valid <= 1'b0;
        clr <= 1'b0;
        w = 0;
        do begin
            @(posedge core_clk);
            #1;
            w++;
        end while (done !== 1'b1 && w < 60);
        m = 32'hFFFFFFFF;
        sz = size_word;
        if (r.op inside {write_ord_byte, write_int_byte}) begin
            m = BYTE_MASK;
            sz = size_byte;
        end
        if (r.op inside {write_ord_half, write_int_half}) begin
            m = HALF_MASK;
            sz = size_half;
        end
        check("done", done, 1);
        check("fault_code", fault_code, r.fc);
        check("fault_valid", fault_valid, r.fc != flt_none);
        check("overflow", overflow_flag_bit, r.of);
        check("beat count", beat_cnt, r.nb);
        if (r.nb > 0) begin
            check("size", beat_size, sz);
        end
        for (int k = 0; k < r.nb; k++) begin
            check("addr", beat_addr[k], r.ad + 4 * k);
            check("data", beat_data[k], req_src[32*k+:32] & m);
        end
        @(posedge core_clk);
        #1;
        check("done pulse", done, 0);
    endtask

    // ==========================================================
    // watchdog
    initial begin
        repeat (5000) @(posedge core_clk);
        n_errors++;
        stop_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        n_errors = 0;
        checked = 0;
        rst_b = 1'b0;
        req_valid = 1'b0;
        req_op = write_word;
        req_src_num = 5'h00;
        req_addr = 32'h00000000;
        req_src = '0;
        req_prot = 1'b0;
        unal_fault_en = 1'b0;
        overflow_mask_bit = 1'b0;
        slow = 1'b0;
        clr = 1'b1;
        repeat (10) @(posedge core_clk);
        #1;
        // outputs quiet while reset holds
        check("ready in reset", req_ready, 0);
        check("valid in reset", mem_wr_valid, 0);
        check("done in reset", done, 0);
        check("size in reset", mem_wr_size, size_word);
        @(posedge core_clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            run(rows[i], 1'b0);
        end
        // stalled write path: beats must stand until taken
        run(rows[10], 1'b1);
        run(rows[19], 1'b1);
        run(rows[4], 1'b1);
        stop_test();
    end
endmodule
